// ===== design/afm_monitor.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "afm_regs.svh"

module afm_monitor #(
    parameter int MON_CYC = `AFM_MON_CYC,
    parameter int DLY_CYC = `AFM_DLY_CYC,
    parameter int PIN_CYC = `AFM_PIN_CYC
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire afm_pkg::afm_apb_req_t apb_i,
    output var  afm_pkg::afm_apb_rsp_t apb_o,
    input  wire logic [7:0]            flux_mt_i,
    input  wire logic [11:0]           angle_err_i,
    input  wire logic [11:0]           angle_raw_i,
    input  wire logic                  angle_upd_i,
    input  wire logic                  user_mode_i,
    output var  afm_pkg::afm_word_t    word_o,
    output      logic                  fault_n_o,
    output      logic                  pulse_run_o,
    output      logic                  irq_o
);

    // ************************************************************
    // State
    // ************************************************************
    afm_pkg::afm_state_t s_q;
    afm_pkg::afm_state_t s_d;

    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        mon_tick;
    logic        pin_tick;
    logic        flux_new;
    logic        trk_new;
    logic        eval_new;
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic [11:0] ang_new;

    assign setup    = apb_i.psel && !apb_i.penable;
    assign access   = apb_i.psel && apb_i.penable;
    assign wr       = access && apb_i.pwrite;
    assign mapped   = apb_i.paddr == `AFM_ADDR_CTRL || apb_i.paddr == `AFM_ADDR_STATUS
                   || apb_i.paddr == `AFM_ADDR_IRQ_STS || apb_i.paddr == `AFM_ADDR_IRQ_CLR
                   || apb_i.paddr == `AFM_ADDR_IRQ_EN;
    assign mon_tick = s_q.mon_cnt == '0;
    assign pin_tick = s_q.pin_cnt == '0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        ev  = '0;
        clr = '0;

        // Detectors, each masked by its disable bit
        flux_new = (flux_mt_i < `AFM_FLUX_MIN_MT)
                && !s_q.diag_disable[`AFM_DIS_FLUX];
        trk_new  = (angle_err_i >= `AFM_TRK_MAX_LSB)
                && !s_q.diag_disable[`AFM_DIS_TRK];
        eval_new = flux_new || trk_new;

        // Periodic evaluation
        if (mon_tick) begin
            s_d.mon_cnt = 20'(MON_CYC - 1);
            s_d.flux_f  = flux_new;
            s_d.trk_f   = trk_new;
            s_d.eval    = eval_new;
        end else begin
            s_d.mon_cnt = s_q.mon_cnt - 20'h00001;
        end

        // A change restarts the reporting delay; clearing goes the same way
        if (mon_tick && eval_new != s_q.eval) begin
            s_d.pend     = eval_new;
            s_d.dly_run  = 1'b1;
            s_d.pend_vld = 1'b0;
            s_d.dly_cnt  = 20'(DLY_CYC - 1);
        end else if (s_q.dly_run) begin
            if (s_q.dly_cnt == '0) begin
                s_d.dly_run  = 1'b0;
                s_d.pend_vld = 1'b1;
            end else begin
                s_d.dly_cnt = s_q.dly_cnt - 20'h00001;
            end
        end else if (s_q.pend_vld && angle_upd_i) begin
            s_d.rep      = s_q.pend;
            s_d.pend_vld = 1'b0;
        end

        // Serial angle word, shifted by the zero offset
        ang_new = angle_raw_i - s_q.zero;
        s_d.word.angle_code     = ang_new;
        s_d.word.err_bit        = !s_d.rep;
        s_d.word.parity_bit_one = s_d.rep ? ^ang_new[11:6] : ~^ang_new[11:6];
        s_d.word.parity_bit_two = s_d.rep ? ^ang_new[5:0] : ~^ang_new[5:0];

        // Fault pin is only refreshed on its own period
        if (pin_tick) begin
            s_d.pin_cnt = 14'(PIN_CYC - 1);
            s_d.pin_n   = !(s_q.rep || user_mode_i);
        end else begin
            s_d.pin_cnt = s_q.pin_cnt - 14'h0001;
        end

        // Register writes
        if (wr && apb_i.paddr == `AFM_ADDR_CTRL) begin
            s_d.diag_disable = apb_i.pwdata[`AFM_CTRL_DIS_LSB +: 2];
            s_d.zero         = apb_i.pwdata[`AFM_CTRL_ZERO_LSB +: 12];
        end
        if (wr && apb_i.paddr == `AFM_ADDR_IRQ_EN) begin
            s_d.irq_en = apb_i.pwdata[1:0];
        end
        if (wr && apb_i.paddr == `AFM_ADDR_IRQ_CLR) begin
            clr = apb_i.pwdata[1:0];
        end

        // Events on the reported state; a new event beats a clear
        ev[`AFM_IRQ_SET]   = s_d.rep && !s_q.rep;
        ev[`AFM_IRQ_CLEAR] = !s_d.rep && s_q.rep;
        s_d.irq_sts = (s_q.irq_sts & ~clr) | ev;
        s_d.irq     = |(s_d.irq_sts & s_d.irq_en);

        // Read data is caught in the setup cycle so the access needs no wait
        if (setup) begin
            unique case (apb_i.paddr)
                `AFM_ADDR_CTRL:    s_d.rdata = {4'h0, s_q.zero, 14'h0000, s_q.diag_disable};
                `AFM_ADDR_STATUS:  s_d.rdata = {28'h0000000, s_q.pin_n, s_q.trk_f,
                                                s_q.flux_f, s_q.rep};
                `AFM_ADDR_IRQ_STS: s_d.rdata = {30'h00000000, s_q.irq_sts};
                `AFM_ADDR_IRQ_EN:  s_d.rdata = {30'h00000000, s_q.irq_en};
                default:           s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s_q       <= '0;
            s_q.pin_n <= `AFM_PIN_RST;
            s_q.word  <= `AFM_WORD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign apb_o.pready  = 1'b1;
    assign apb_o.pslverr = access && !mapped;
    assign apb_o.prdata  = s_q.rdata;
    assign word_o        = s_q.word;
    assign fault_n_o     = s_q.pin_n;
    // Pulse generators never stop on a fault, so the motor loop keeps a clock
    assign pulse_run_o   = 1'b1;
    assign irq_o         = s_q.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_rep_at_upd;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (s_q.rep != $past(s_q.rep)) |-> $past(angle_upd_i && s_q.pend_vld);
    endproperty
    a_rep_at_upd: assert property (p_rep_at_upd) else $error("report moved off update");

    property p_flux;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (mon_tick && flux_mt_i < `AFM_FLUX_MIN_MT && !s_q.diag_disable[`AFM_DIS_FLUX])
        |=> s_q.flux_f && s_q.eval;
    endproperty
    a_flux: assert property (p_flux) else $error("low flux not flagged");

    property p_trk;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (mon_tick && angle_err_i >= `AFM_TRK_MAX_LSB && !s_q.diag_disable[`AFM_DIS_TRK])
        |=> s_q.trk_f && s_q.eval;
    endproperty
    a_trk: assert property (p_trk) else $error("tracking lost not flagged");

    property p_eval_tick;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !mon_tick |=> $stable(s_q.eval);
    endproperty
    a_eval_tick: assert property (p_eval_tick) else $error("evaluation off period");

    property p_pulse;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_q.rep |-> pulse_run_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulses stopped on fault");

    property p_parity;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (^{word_o.parity_bit_one, word_o.angle_code[11:6]} == word_o.err_bit)
        && (^{word_o.parity_bit_two, word_o.angle_code[5:0]} == word_o.err_bit)
        && (word_o.err_bit == !s_q.rep);
    endproperty
    a_parity: assert property (p_parity) else $error("parity or error bit wrong");

    property p_pin_level;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (pin_tick && !user_mode_i) |=> fault_n_o == !$past(s_q.rep);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("fault pin level wrong");

    property p_pin_period;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !pin_tick |=> $stable(fault_n_o);
    endproperty
    a_pin_period: assert property (p_pin_period) else $error("fault pin off period");

    property p_user;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (pin_tick && user_mode_i) |=> !fault_n_o;
    endproperty
    a_user: assert property (p_user) else $error("user mode pin not low");

    property p_angle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 word_o.angle_code == 12'($past(angle_raw_i) - $past(s_q.zero));
    endproperty
    a_angle: assert property (p_angle) else $error("angle code offset wrong");

    property p_disable;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (mon_tick && s_q.diag_disable == 2'h3) |=> !s_q.eval;
    endproperty
    a_disable: assert property (p_disable) else $error("disabled detector flagged");

    property p_irq_level;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        irq_o == |(s_q.irq_sts & s_q.irq_en);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_sts_set;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (s_q.rep && !$past(s_q.rep)) |-> s_q.irq_sts[`AFM_IRQ_SET];
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("fault event not latched");

    property p_sts_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!s_q.rep && $past(s_q.rep)) |-> s_q.irq_sts[`AFM_IRQ_CLEAR];
    endproperty
    a_sts_clear: assert property (p_sts_clear) else $error("clear event not latched");

    property p_sts_sticky;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (s_q.irq_sts[`AFM_IRQ_SET] && !(wr && apb_i.paddr == `AFM_ADDR_IRQ_CLR
            && apb_i.pwdata[`AFM_IRQ_SET])) |=> s_q.irq_sts[`AFM_IRQ_SET];
    endproperty
    a_sts_sticky: assert property (p_sts_sticky) else $error("status bit dropped by itself");

    property p_slverr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        apb_o.pslverr |-> access;
    endproperty
    a_slverr: assert property (p_slverr) else $error("bus error outside access");

    property p_unmapped_rd;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (access && !apb_i.pwrite && !mapped && $past(setup)) |-> apb_o.prdata == 32'h00000000;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    property p_mon_range;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_q.mon_cnt < 20'(MON_CYC);
    endproperty
    a_mon_range: assert property (p_mon_range) else $error("monitor counter out of range");

    property p_mon_reload;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        mon_tick |=> s_q.mon_cnt == 20'(MON_CYC - 1);
    endproperty
    a_mon_reload: assert property (p_mon_reload) else $error("monitor period wrong");

    property p_dly_range;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_q.dly_cnt < 20'(DLY_CYC);
    endproperty
    a_dly_range: assert property (p_dly_range) else $error("delay counter out of range");

    property p_pin_range;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_q.pin_cnt < 14'(PIN_CYC);
    endproperty
    a_pin_range: assert property (p_pin_range) else $error("pin counter out of range");

    property p_pin_reload;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        pin_tick |=> s_q.pin_cnt == 14'(PIN_CYC - 1);
    endproperty
    a_pin_reload: assert property (p_pin_reload) else $error("pin refresh period wrong");

    property p_clear_delay;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (mon_tick && s_q.eval && !eval_new) |=> !s_q.eval && s_q.dly_run && !s_q.pend_vld;
    endproperty
    a_clear_delay: assert property (p_clear_delay) else $error("clearing not delayed");

endmodule
`default_nettype wire

// ===== inc/afm_pkg.sv
package afm_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } afm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } afm_apb_rsp_t;

    typedef struct packed {
        logic        parity_bit_one;
        logic        parity_bit_two;
        logic        err_bit;
        logic [11:0] angle_code;
    } afm_word_t;

    typedef struct packed {
        logic [1:0]  diag_disable;
        logic [11:0] zero;
        logic [1:0]  irq_en;
        logic [1:0]  irq_sts;
        logic        irq;
        logic        flux_f;
        logic        trk_f;
        logic        eval;
        logic        pend;
        logic        dly_run;
        logic        pend_vld;
        logic        rep;
        logic [19:0] mon_cnt;
        logic [19:0] dly_cnt;
        logic [13:0] pin_cnt;
        logic        pin_n;
        afm_word_t   word;
        logic [31:0] rdata;
    } afm_state_t;
endpackage

// ===== inc/afm_regs.svh
// Operation
// - Report a detected fault at an angle update, about 2.7 ms after detection.
// - Flag a flux fault while field strength is below 10 mT.
// - Flag tracking lost while servo angle error is 2 degrees or more.
// - Evaluate the fault state once every 2.56 ms.
// - Keep incremental and commutation pulses running during a fault.
// - Normal: odd parity in both bits, error bit 1; fault: even, 0.
// - Fault pin low while a fault is present, high when normal.
// - Refresh the fault pin level once every 80 us.
// - Return to normal indications by itself once the fault clears.
// - Hold the fault pin low while in user mode.
// - Angle is a 12-bit code, one step per 360/4096 degrees.
// - Report the configured zero position as angle code zero.
// - Disable bit 1 masks the flux detector, bit 0 tracking; both reset zero.
`ifndef AFM_REGS_SVH
`define AFM_REGS_SVH
`define AFM_CLK_NS        8
`define AFM_MON_NS        2560000
`define AFM_DLY_NS        2700000
`define AFM_PIN_NS        80000
`define AFM_MON_CYC       (`AFM_MON_NS / `AFM_CLK_NS)
`define AFM_DLY_CYC       (`AFM_DLY_NS / `AFM_CLK_NS)
`define AFM_PIN_CYC       (`AFM_PIN_NS / `AFM_CLK_NS)
`define AFM_FLUX_MIN_MT   8'h0a
// 2 degrees is 22.76 steps; an error of 23 steps or more is at or over 2 degrees
`define AFM_TRK_MAX_LSB   12'h017
`define AFM_ADDR_CTRL     12'h000
`define AFM_ADDR_STATUS   12'h004
`define AFM_ADDR_IRQ_STS  12'h008
`define AFM_ADDR_IRQ_CLR  12'h00c
`define AFM_ADDR_IRQ_EN   12'h010
`define AFM_CTRL_DIS_LSB  0
`define AFM_CTRL_ZERO_LSB 16
`define AFM_DIS_FLUX      1
`define AFM_DIS_TRK       0
`define AFM_IRQ_SET       0
`define AFM_IRQ_CLEAR     1
`define AFM_PIN_RST       1'h1
// Normal word for angle zero: odd parity in both bits, error bit set
`define AFM_WORD_RST      15'h7000
`endif

// ===== testbench/afm_front_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Angle front end: update strobe and raw angle
// ****************************************
module afm_front_model #(
    parameter int UPD_CYC = 10
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    output      logic [11:0] angle_raw_o,
    output      logic        angle_upd_o
);
    int cnt;

    // Raw angle moves only with a strobe, so a word sampled between strobes is stable
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            angle_upd_o <= 1'b0;
            angle_raw_o <= 12'h000;
        end else begin
            cnt <= (cnt == UPD_CYC - 1) ? 0 : cnt + 1;
            angle_upd_o <= (cnt == UPD_CYC - 1);
            if (cnt == UPD_CYC - 1) begin
                angle_raw_o <= angle_raw_o + 12'($urandom_range(1, 300));
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int MON = 20;
    localparam int DLY = 30;
    localparam int PIN = 8;
    localparam int WAITC = 2 * MON + DLY + 3 * PIN + 40;
    logic                  core_clk;
    logic                  rst_n;
    logic                  user_mode;
    logic                  upd;
    logic                  fault_n;
    logic                  prun;
    logic                  irq;
    logic                  sl;
    logic [7:0]            flux;
    logic [11:0]           aerr;
    logic [11:0]           raw;
    logic [11:0]           zero;
    logic [31:0]           rd;
    afm_pkg::afm_apb_req_t req;
    afm_pkg::afm_apb_rsp_t rsp;
    afm_pkg::afm_word_t    word;
    int                    err_count;
    int                    n_compared;
    int                    cyc;

    afm_front_model u_front (.core_clk_i(core_clk), .rst_n_i(rst_n), .angle_raw_o(raw),
        .angle_upd_o(upd));
    afm_monitor #(.MON_CYC(MON), .DLY_CYC(DLY), .PIN_CYC(PIN)) u_dut (.core_clk_i(core_clk),
        .rst_n_i(rst_n), .apb_i(req), .apb_o(rsp), .flux_mt_i(flux), .angle_err_i(aerr),
        .angle_raw_i(raw), .angle_upd_i(upd), .user_mode_i(user_mode), .word_o(word),
        .fault_n_o(fault_n), .pulse_run_o(prun), .irq_o(irq));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic afm_pkg::afm_word_t exp_word(input logic [11:0] r, input logic f);
        logic [11:0] a;
        a = r - zero;
        return {^a[11:6] ^ ~f, ^a[5:0] ^ ~f, ~f, a};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (rsp.pready === 1'b1) break;
        end
        rd = rsp.prdata;
        sl = rsp.pslverr;
        req <= '0;
    endtask

    // Settles through one monitor tick, the report delay, an update and a pin tick
    task automatic expect_state(input logic f, input logic pin_low);
        repeat (WAITC) @(posedge core_clk);
        @(posedge core_clk iff upd);
        repeat (2) @(posedge core_clk);
        #1;
        chk("word", {17'h0, exp_word(raw, f)}, {17'h0, word});
        chk("fault_n", {31'h0, ~pin_low}, {31'h0, fault_n});
        chk("pulse_run", 32'h1, {31'h0, prun});
        apb(1'b0, 12'h004, 32'h0);
        chk("status", {31'h0, f}, {31'h0, rd[0]});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(54));
        {rst_n, user_mode} = 2'b00;
        req = '0;
        flux = 8'h20;
        aerr = 12'h000;
        zero = 12'h000;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, sl});
        apb(1'b1, 12'h010, 32'h1);
        expect_state(1'b0, 1'b0);
        flux <= 8'h09;
        expect_state(1'b1, 1'b1);
        chk("irq_raised", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h00c, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        flux <= 8'h0a + 8'($urandom_range(0, 200));
        expect_state(1'b0, 1'b0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h008, 32'h0);
        chk("irq_sts", 32'h2, rd);
        apb(1'b1, 12'h00c, 32'h3);
        aerr <= 12'h017;
        expect_state(1'b1, 1'b1);
        aerr <= 12'h016;
        expect_state(1'b0, 1'b0);
        flux <= 8'($urandom_range(0, 9));
        aerr <= 12'h017 + 12'($urandom_range(0, 900));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 32'(i));
            expect_state(i != 3, i != 3);
        end
        aerr <= 12'h000;
        apb(1'b1, 12'h000, 32'h2);
        expect_state(1'b0, 1'b0);
        flux <= 8'h40;
        user_mode <= 1'b1;
        expect_state(1'b0, 1'b1);
        user_mode <= 1'b0;
        repeat (3) begin
            zero = 12'($urandom);
            apb(1'b1, 12'h000, {4'h0, zero, 16'h0000});
            expect_state(1'b0, 1'b0);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
